// [drive_status_output_allocator.sv]
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module drive_status_output_allocator (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [drive_status_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read address
  input  wire logic [drive_status_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // drive state
  input  wire logic [15:0]               out_freq,
  input  wire logic                      freq_reverse,
  input  wire logic                      drive_running,
  input  wire logic [15:0]               set_freq,
  input  wire logic [15:0]               out_current,
  input  wire logic                      limit_active,
  // settings toward the drive
  output logic [15:0]                    current_limit_level,
  // open-collector terminals, oe high = conducting
  output logic                           term_run_o,
  output logic                           term_run_oe,
  output logic                           term_fu_o,
  output logic                           term_fu_oe,
  // interrupt
  output logic                           irq
);
  import drive_status_pkg::*;

  // ----------------------------------------------------------------
  // settings and bus state
  // ----------------------------------------------------------------
  logic [2:0]    run_fn_q;
  logic [2:0]    fu_fn_q;
  logic [6:0]    band_q;
  logic [15:0]   pri_q;
  logic [15:0]   rev_q;
  logic [15:0]   start_q;
  logic [15:0]   open_q;
  logic [15:0]   limit_q;
  logic [NEV-1:0] mask_q;
  logic [NEV-1:0] w1c_d;
  logic [NEV-1:0] irq_stat;
  logic          irq_w;
  logic          reject_q;

  logic          aw_have_q;
  logic          w_have_q;
  logic [AW-1:0] waddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          do_wr;
  logic [31:0]   rdata_d;
  logic          rhit_d;
  logic          whit_d;
  logic [8:0]    display;

  status_flags_if fl_if ();

  // ----------------------------------------------------------------
  // byte-lane merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // axi4-lite write channels
  // ----------------------------------------------------------------
  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;

  // write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      waddr_q       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      s_axi_awready <= 1'b0;
      waddr_q       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q     <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // write address decode
  always_comb begin
    unique case (waddr_q)
      A_ASSIGN, A_DISPLAY, A_BAND, A_PRI, A_REV, A_START,
      A_OPEN, A_LIMIT, A_STATUS, A_IRQ_STAT, A_IRQ_MASK: whit_d = 1'b1;
      default:                                           whit_d = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= whit_d ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // setting registers
  // ----------------------------------------------------------------
  logic [31:0] wm_assign;
  logic [31:0] wm_band;
  logic [31:0] wm_start;
  assign wm_assign = merge({25'h0, fu_fn_q, 1'b0, run_fn_q},
                           wdata_q, wstrb_q);
  assign wm_band   = merge({25'h0, band_q}, wdata_q, wstrb_q);
  assign wm_start  = merge({16'h0, start_q}, wdata_q, wstrb_q);

  // terminal assignment, illegal digits keep the old function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_fn_q <= RST_RUN_FN;                                   // RQ2
      fu_fn_q  <= RST_FU_FN;                                    // RQ2
    end else if (do_wr && waddr_q == A_ASSIGN) begin
      if (wm_assign[RUN_LSB +: 3] <= FN_MAX)                    // RQ13
        run_fn_q <= wm_assign[RUN_LSB +: 3];                    // RQ1
      if (wm_assign[FU_LSB +: 3] <= FN_MAX)                     // RQ13
        fu_fn_q <= wm_assign[FU_LSB +: 3];                      // RQ1
    end
  end

  // arrival band, 0 to 100 percent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      band_q <= RST_BAND;
    end else if (do_wr && waddr_q == A_BAND &&
                 wm_band[6:0] <= BAND_MAX &&
                 wm_band[31:7] == '0) begin
      band_q <= wm_band[6:0];                                   // RQ8
    end
  end

  // starting frequency, 0 to 60 Hz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= RST_START;
    end else if (do_wr && waddr_q == A_START &&
                 wm_start[15:0] <= START_MAX) begin
      start_q <= wm_start[15:0];                                // RQ12
    end
  end

  // plain 16-bit settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_q   <= RST_PRI;
      rev_q   <= REV_UNSET;                                     // RQ11
      open_q  <= RST_OPEN;
      limit_q <= RST_LIMIT;
    end else if (do_wr) begin
      if (waddr_q == A_PRI)
        pri_q <= 16'(merge({16'h0, pri_q}, wdata_q, wstrb_q));
      if (waddr_q == A_REV)
        rev_q <= 16'(merge({16'h0, rev_q}, wdata_q, wstrb_q));
      if (waddr_q == A_OPEN)
        open_q <= 16'(merge({16'h0, open_q}, wdata_q, wstrb_q));
      if (waddr_q == A_LIMIT)
        limit_q <= 16'(merge({16'h0, limit_q}, wdata_q, wstrb_q));
    end
  end

  // refused setting writes raise an event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reject_q <= 1'b0;
    end else begin
      reject_q <= do_wr && (
        (waddr_q == A_ASSIGN && (wm_assign[RUN_LSB +: 3] > FN_MAX ||
                                 wm_assign[FU_LSB +: 3] > FN_MAX)) ||
        (waddr_q == A_BAND && (wm_band[6:0] > BAND_MAX ||
                               wm_band[31:7] != '0)) ||
        (waddr_q == A_START && wm_start[15:0] > START_MAX));    // RQ13
    end
  end

  // interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
    end else if (do_wr && waddr_q == A_IRQ_MASK) begin
      mask_q <= NEV'(merge({26'h0, mask_q}, wdata_q, wstrb_q));
    end
  end

  // write-one-to-clear strobe
  always_comb begin
    w1c_d = '0;
    if (do_wr && waddr_q == A_IRQ_STAT && wstrb_q[0])
      w1c_d = wdata_q[NEV-1:0];
  end

  // ----------------------------------------------------------------
  // flag evaluation and interrupt
  // ----------------------------------------------------------------
  flag_eval u_eval (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .out_freq      (out_freq),
    .freq_reverse  (freq_reverse),
    .drive_running (drive_running),
    .set_freq      (set_freq),
    .out_current   (out_current),
    .limit_active  (limit_active),
    .band          (band_q),
    .pri_thr       (pri_q),
    .rev_thr       (rev_q),
    .start_freq    (start_q),
    .open_level    (open_q),
    .fl            (fl_if.src)
  );

  irq_status u_irq (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .fl       (fl_if.dst),
    .reject   (reject_q),
    .w1c      (w1c_d),
    .mask     (mask_q),
    .status_q (irq_stat),
    .irq_q    (irq_w)
  );

  assign irq = irq_w;

  // ----------------------------------------------------------------
  // terminals
  // ----------------------------------------------------------------
  // each terminal follows the flag its digit picks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_run_oe <= 1'b0;
      term_fu_oe  <= 1'b0;
      term_run_o  <= 1'b0;
      term_fu_o   <= 1'b0;
    end else begin
      term_run_oe <= fl_if.flag[run_fn_q];                      // RQ1
      term_fu_oe  <= fl_if.flag[fu_fn_q];                       // RQ1 RQ9
      term_run_o  <= 1'b0;
      term_fu_o   <= 1'b0;
    end
  end

  // stall level toward the drive
  always_ff @(posedge aclk) begin
    if (!aresetn) current_limit_level <= RST_LIMIT;
    else          current_limit_level <= limit_q;
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  // display: leading zero digit blanked
  always_comb begin
    display = '0;
    display[FU_LSB-4 +: 4] = {1'b0, fu_fn_q};
    if (run_fn_q != FN_RUN) begin                               // RQ3
      display[FU_LSB +: 4]  = {1'b0, run_fn_q};
      display[SHOW2_BIT]    = 1'b1;
    end
  end

  // read mux
  always_comb begin
    rdata_d = '0;
    rhit_d  = 1'b1;
    unique case (s_axi_araddr)
      A_ASSIGN:   rdata_d = {25'h0, fu_fn_q, 1'b0, run_fn_q};
      A_DISPLAY:  rdata_d = {23'h0, display};
      A_BAND:     rdata_d = {25'h0, band_q};
      A_PRI:      rdata_d = {16'h0, pri_q};
      A_REV:      rdata_d = {16'h0, rev_q};
      A_START:    rdata_d = {16'h0, start_q};
      A_OPEN:     rdata_d = {16'h0, open_q};
      A_LIMIT:    rdata_d = {16'h0, limit_q};
      A_STATUS:   rdata_d = {25'h0, term_fu_oe, term_run_oe,
                             fl_if.flag};
      A_IRQ_STAT: rdata_d = {26'h0, irq_stat};
      A_IRQ_MASK: rdata_d = {26'h0, mask_q};
      default:    rhit_d  = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rhit_d ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule : drive_status_output_allocator

// [drive_status_pkg.sv]
// Notes on behaviour
// RQ1 - each of the two status terminals gets its function from its own digit of a two-digit assignment setting.
// RQ2 - after reset the operating terminal carries the operating flag and the other carries the level flag.
// RQ3 - a leading assignment digit of zero is blanked on the display, leaving one digit shown.
// RQ4 - code 0 flags the drive as operating while it runs above the starting frequency.
// RQ5 - code 1 flags frequency arrival once the output frequency is within the arrival band of the setpoint.
// RQ6 - code 3 flags the current-limit alarm while the stall-prevention limit is acting.
// RQ7 - code 4 flags an open motor when output current falls below its level while operating.
// RQ8 - the arrival band takes 0 to 100 percent of the setpoint and the flag changes on entering the band.
// RQ9 - code 2 makes the level terminal conduct above the sensing threshold and stay open below it.
// RQ10 - with a reverse threshold set, forward uses the primary threshold and reverse the reverse one.
// RQ11 - a reverse threshold at its sentinel makes the primary threshold serve both directions.
// RQ12 - the starting frequency holds 0 to 60 Hz and is the operating flag's threshold.
// RQ13 - an assignment digit above code 4 is refused and that terminal keeps its old function.
// RQ14 - band and threshold checks use the output frequency's magnitude, ignoring direction.
package drive_status_pkg;

  // ----------------------------------------------------------------
  // function codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_RUN     = 3'h0,
    FN_ARRIVED = 3'h1,
    FN_LEVEL   = 3'h2,
    FN_LIMIT   = 3'h3,
    FN_OPEN    = 3'h4
  } func_t;

  localparam logic [2:0]  FN_MAX       = 3'h4;
  localparam int          NFLAG        = 5;
  localparam int          NEV          = 6;
  localparam int          EV_REJECT    = 5;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          AW           = 6;
  localparam logic [5:0]  A_ASSIGN     = 6'h00;
  localparam logic [5:0]  A_DISPLAY    = 6'h04;
  localparam logic [5:0]  A_BAND       = 6'h08;
  localparam logic [5:0]  A_PRI        = 6'h0C;
  localparam logic [5:0]  A_REV        = 6'h10;
  localparam logic [5:0]  A_START      = 6'h14;
  localparam logic [5:0]  A_OPEN       = 6'h18;
  localparam logic [5:0]  A_LIMIT      = 6'h1C;
  localparam logic [5:0]  A_STATUS     = 6'h20;
  localparam logic [5:0]  A_IRQ_STAT   = 6'h24;
  localparam logic [5:0]  A_IRQ_MASK   = 6'h28;

  // ----------------------------------------------------------------
  // fields and reset values (frequencies in 0.01 Hz)
  // ----------------------------------------------------------------
  localparam int          RUN_LSB      = 0;
  localparam int          FU_LSB       = 4;
  localparam int          SHOW2_BIT    = 8;
  localparam logic [2:0]  RST_RUN_FN   = FN_RUN;
  localparam logic [2:0]  RST_FU_FN    = FN_LEVEL;
  localparam logic [6:0]  BAND_MAX     = 7'h64;
  localparam logic [6:0]  RST_BAND     = 7'h0A;
  localparam logic [15:0] START_MAX    = 16'h1770;
  localparam logic [15:0] RST_START    = 16'h0032;
  localparam logic [15:0] RST_PRI      = 16'h1770;
  localparam logic [15:0] REV_UNSET    = 16'h270F;
  localparam logic [15:0] RST_OPEN     = 16'h0000;
  localparam logic [15:0] RST_LIMIT    = 16'h0096;
  localparam logic [23:0] PCT_SCALE    = 24'h000064;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : drive_status_pkg

// [status_flags_if.sv]
`timescale 1ns/1ps
interface status_flags_if;
  import drive_status_pkg::*;
  logic [NFLAG-1:0] flag;
  modport src (output flag);
  modport dst (input flag);
endinterface : status_flags_if

// [flag_eval.sv]
`timescale 1ns/1ps
module flag_eval (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // drive state
  input  wire logic [15:0] out_freq,
  input  wire logic        freq_reverse,
  input  wire logic        drive_running,
  input  wire logic [15:0] set_freq,
  input  wire logic [15:0] out_current,
  input  wire logic        limit_active,
  // settings
  input  wire logic [6:0]  band,
  input  wire logic [15:0] pri_thr,
  input  wire logic [15:0] rev_thr,
  input  wire logic [15:0] start_freq,
  input  wire logic [15:0] open_level,
  // evaluated flags
  status_flags_if.src      fl
);
  import drive_status_pkg::*;

  logic [15:0] mag;
  logic [15:0] diff;
  logic [15:0] thr;
  logic [23:0] lhs;
  logic [23:0] rhs;
  logic        operating;

  // magnitude, distance to setpoint, threshold pick
  always_comb begin
    mag  = out_freq[15] ? 16'(-out_freq) : out_freq;            // RQ14
    diff = (mag > set_freq) ? 16'(mag - set_freq)
                            : 16'(set_freq - mag);
    thr  = (freq_reverse && rev_thr != REV_UNSET) ? rev_thr      // RQ10
                                                  : pri_thr;     // RQ11
    lhs  = 24'(diff) * PCT_SCALE;
    rhs  = 24'(set_freq) * 24'(band);
    operating = drive_running && (mag > start_freq);            // RQ12
  end

  // registered flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl.flag <= '0;
    end else begin
      fl.flag[FN_RUN]     <= operating;                         // RQ4
      fl.flag[FN_ARRIVED] <= drive_running && (lhs <= rhs);     // RQ5 RQ8
      fl.flag[FN_LEVEL]   <= mag > thr;                         // RQ9
      fl.flag[FN_LIMIT]   <= limit_active;                      // RQ6
      fl.flag[FN_OPEN]    <= operating &&
                             (out_current < open_level);        // RQ7
    end
  end

endmodule : flag_eval

// [irq_status.sv]
`timescale 1ns/1ps
module irq_status (
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // event sources
  status_flags_if.dst         fl,
  input  wire logic           reject,
  // software side
  input  wire logic [drive_status_pkg::NEV-1:0] w1c,
  input  wire logic [drive_status_pkg::NEV-1:0] mask,
  output logic [drive_status_pkg::NEV-1:0]      status_q,
  output logic                irq_q
);
  import drive_status_pkg::*;

  logic [NFLAG-1:0] prev_q;
  logic [NEV-1:0]   ev;

  // rising flags and refused writes are events
  assign ev = {reject, fl.flag & ~prev_q};

  // edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) prev_q <= '0;
    else          prev_q <= fl.flag;
  end

  // sticky bits, a new event beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) status_q <= '0;
    else          status_q <= (status_q & ~w1c) | ev;
  end

  // level interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_q <= 1'b0;
    else          irq_q <= |(((status_q & ~w1c) | ev) & mask);
  end

endmodule : irq_status

// [terminal_sense.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// relay inputs on the two open-collector terminals
// ------------------------------------------------------------
module terminal_sense (
  // terminal pins from the drive
  input  wire logic run_o,
  input  wire logic run_oe,
  input  wire logic lvl_o,
  input  wire logic lvl_oe,
  // levels seen by the relay coil
  output logic      run_line,
  output logic      lvl_line
);
  // pull-up wins while the transistor is open
  assign run_line = run_oe ? run_o : 1'b1;
  assign lvl_line = lvl_oe ? lvl_o : 1'b1;
endmodule : terminal_sense

// [drive_status_asserts.sv]
`timescale 1ns/1ps
module drive_status_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // terminals and interrupt
  input wire logic        term_run_o,
  input wire logic        term_fu_o,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write taken in one edge, answered two edges later
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_wait;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence
  wr_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 wr_wait)
    else $error("write not answered in two cycles");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  term_data_a: assert property (!term_run_o && !term_fu_o)
    else $error("terminal data not low");
  irq_clear_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt fell without a write");
endmodule : drive_status_asserts

bind drive_status_output_allocator drive_status_asserts u_chk (.*);

// [drive_status_output_allocator_bench.sv]
`timescale 1ns/1ps
module drive_status_output_allocator_bench;
  import drive_status_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0]   wdata = '0, rdata, rd;
  logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp, resp;
  logic [15:0]   out_freq = '0, set_freq = '0, out_current = '0, lim_lvl;
  logic          freq_reverse = 0, drive_running = 0, limit_active = 0;
  logic          run_o, run_oe, lvl_o, lvl_oe, irq, run_line, lvl_line;
  int            num_errors = 0, total_checks = 0, cycles = 0;
  // 100 MHz clock
  always #5 aclk = ~aclk;
  drive_status_output_allocator u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .out_freq(out_freq),
    .freq_reverse(freq_reverse), .drive_running(drive_running),
    .set_freq(set_freq), .out_current(out_current),
    .limit_active(limit_active), .current_limit_level(lim_lvl),
    .term_run_o(run_o), .term_run_oe(run_oe), .term_fu_o(lvl_o),
    .term_fu_oe(lvl_oe), .irq(irq));
  terminal_sense u_relay (.run_o(run_o), .run_oe(run_oe), .lvl_o(lvl_o),
    .lvl_oe(lvl_oe), .run_line(run_line), .lvl_line(lvl_line));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [AW-1:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  task automatic drv(input logic [15:0] f, input logic rev, run);
    @(posedge aclk);
    out_freq      <= f;
    freq_reverse  <= rev;
    drive_running <= run;
    repeat (3) @(posedge aclk);
  endtask : drv
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check("limit out", 32'(lim_lvl), 32'h96);
    rd_reg(A_ASSIGN);
    check("assign", rd, 32'h20);
    rd_reg(A_DISPLAY);
    check("display", rd, 32'h2);
    rd_reg(A_REV);
    check("rev thr", rd, 32'h270F);
    rd_reg(6'h2C);
    check("hole resp", 32'(resp), 32'h2);
  endtask : t_reset
  task automatic t_run;
    drv(16'h0033, 1'b0, 1'b1);
    check("run above", 32'(run_line), 32'h0);
    drv(16'h0032, 1'b0, 1'b1);
    check("run at start", 32'(run_line), 32'h1);
    drv(16'hFFCD, 1'b1, 1'b1);
    check("run reverse", 32'(run_line), 32'h0);
    drv(16'h0100, 1'b0, 1'b0);
    check("run stopped", 32'(run_line), 32'h1);
  endtask : t_run
  task automatic t_level;
    drv(16'h1771, 1'b0, 1'b0);
    check("lvl above", 32'(lvl_line), 32'h0);
    drv(16'h1770, 1'b0, 1'b0);
    check("lvl at thr", 32'(lvl_line), 32'h1);
    wr(A_REV, 32'h100);
    drv(16'hFEFF, 1'b1, 1'b0);
    check("lvl reverse", 32'(lvl_line), 32'h0);
    drv(16'h0101, 1'b0, 1'b0);
    check("lvl forward", 32'(lvl_line), 32'h1);
    wr(A_REV, 32'h270F);
    drv(16'hFEFF, 1'b1, 1'b0);
    check("lvl sentinel", 32'(lvl_line), 32'h1);
  endtask : t_level
  task automatic t_assign;
    wr(A_ASSIGN, 32'h31);
    rd_reg(A_DISPLAY);
    check("display two", rd, 32'h113);
    set_freq <= 16'h1000;
    drv(16'h1199, 1'b0, 1'b1);
    check("arrived in", 32'(run_line), 32'h0);
    drv(16'h119A, 1'b0, 1'b1);
    check("arrived out", 32'(run_line), 32'h1);
    limit_active <= 1'b1;
    drv(16'h119A, 1'b0, 1'b1);
    check("limit on", 32'(lvl_line), 32'h0);
    limit_active <= 1'b0;
    wr(A_ASSIGN, 32'h04);
    wr(A_OPEN, 32'h10);
    out_current <= 16'h0008;
    drv(16'h0100, 1'b0, 1'b1);
    check("open low", 32'(run_line), 32'h0);
    check("run on lvl", 32'(lvl_line), 32'h0);
    out_current <= 16'h0020;
    drv(16'h0100, 1'b0, 1'b1);
    check("open high", 32'(run_line), 32'h1);
  endtask : t_assign
  task automatic t_refuse;
    wr(A_IRQ_MASK, 32'h20);
    wr(A_ASSIGN, 32'h57);
    check("bad resp", 32'(resp), 32'h0);
    @(posedge aclk);
    check("irq on", 32'(irq), 32'h1);
    rd_reg(A_ASSIGN);
    check("assign kept", rd, 32'h04);
    wr(A_ASSIGN, 32'h72);
    rd_reg(A_ASSIGN);
    check("one digit", rd, 32'h02);
    wr(A_BAND, 32'h65);
    rd_reg(A_BAND);
    check("band kept", rd, 32'h0A);
    wr(A_START, 32'h1771);
    rd_reg(A_START);
    check("start kept", rd, 32'h32);
    wr(A_START, 32'h1770);
    rd_reg(A_START);
    check("start max", rd, 32'h1770);
    wr(A_IRQ_STAT, 32'h3F);
    check("irq off", 32'(irq), 32'h0);
    wr(6'h2C, 32'h1);
    check("hole wr", 32'(resp), 32'h2);
  endtask : t_refuse
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_run();
    t_level();
    t_assign();
    t_refuse();
    print_verdict();
  end
endmodule : drive_status_output_allocator_bench
